/* hdl/arb_pkg.sv */
// Purpose: Shared constants and carriers for the multi-master bus arbiter
// Assumes: Up to sixteen masters, four-bit master number
// Notes:   Response codes follow the two-bit transfer response encoding
package arb_pkg;
   localparam int          MAX_MASTERS   = 16;
   localparam int          MNUM_W        = 4;
   localparam logic [MNUM_W-1:0] DEFAULT_MASTER = 4'h0;

   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_ERROR    = 2'h1;
   localparam logic [1:0]  RESP_RETRY    = 2'h2;
   localparam logic [1:0]  RESP_SPLIT    = 2'h3;

   localparam logic [1:0]  TRANS_IDLE    = 2'h0;

   // Bus-observed transfer status, all from slaves and the active master
   typedef struct packed {
      logic       ready;
      logic [1:0] resp;
      logic [1:0] trans;
   } bus_status_s;

   // Address-phase owner information broadcast to slaves
   typedef struct packed {
      logic [MNUM_W-1:0] master;
      logic              mastlock;
   } owner_s;
endpackage

/* hdl/prio_pick.sv */
// Purpose: Fixed-priority selector, lowest index wins
// Assumes: Purely combinational, same clock domain as caller
// Notes:   Reports whether any candidate was present
`timescale 1ns/1ps
module prio_pick #(
   parameter int N  = 16,
   parameter int IW = 4
) (
   // Candidates
   input  wire logic [N-1:0]  cand,
   // Result
   output logic              found,
   output logic [IW-1:0]     index
);
   always_comb begin
      found = 1'b0;
      index = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (cand[i]) begin
            found = 1'b1;
            index = IW'(i);
         end
      end
   end
endmodule

/* hdl/bus_arbiter.sv */
// Purpose: Arbiter for a multi-master system bus with lock and split support
// Assumes: All request, lock, ready and split inputs come from logic on clk
// Notes:   Fixed priority, master 0 highest; default master owns an idle bus
`timescale 1ns/1ps

// Summary of operation
// - One request input and one grant output per master, sixteen masters at most.
// - While the owning master holds lock high and is not parked by a split, no other master is granted.
// - Grant marks the master currently chosen as highest-priority requester.
// - Address phase ownership moves to the granted master only when ready is high.
// - Four-bit master number names the master performing the transfer.
// - Master number changes together with the owner's address and control phase.
// - Locked-sequence flag shows a locked owner, timed like the master number.
// - Split bit n releases master n for grant consideration again.
// - Inputs sampled and outputs updated on the rising clock edge.
module bus_arbiter
   import arb_pkg::*;
#(
   parameter int NUM_MASTERS = arb_pkg::MAX_MASTERS
) (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst,
   // Master requests
   input  wire logic [NUM_MASTERS-1:0]    bus_req,
   input  wire logic [NUM_MASTERS-1:0]    lock_req,
   // Bus status and split completions
   input  wire arb_pkg::bus_status_s      status,
   input  wire logic [NUM_MASTERS-1:0]    split_done,
   // Grants and owner broadcast
   output logic [NUM_MASTERS-1:0]         grant,
   output arb_pkg::owner_s                owner
);
   import arb_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State

   logic [NUM_MASTERS-1:0]     grant_q;
   logic [NUM_MASTERS-1:0]     grant_d;
   logic [MNUM_W-1:0]          gnt_num_q;
   logic [MNUM_W-1:0]          gnt_num_d;
   logic                       gnt_lock_q;
   logic                       gnt_lock_d;
   owner_s                     owner_q;
   owner_s                     owner_d;
   logic [MNUM_W-1:0]          data_num_q;
   logic [MNUM_W-1:0]          data_num_d;
   logic                       data_valid_q;
   logic                       data_valid_d;
   logic [NUM_MASTERS-1:0]     parked_q;
   logic [NUM_MASTERS-1:0]     parked_d;
   logic [NUM_MASTERS-1:0]     still_parked;
   logic                       split_seen;
   logic [NUM_MASTERS-1:0]     eligible;
   logic                       pick_found;
   logic [MNUM_W-1:0]          pick_idx;
   logic [MNUM_W-1:0]          next_num;
   logic                       hold_bus;

   ////////////////////////////////////////////////////////////////////////////
   // Constants and helpers

   // Reset value of the grant vector: the default master alone
   localparam logic [NUM_MASTERS-1:0] RESET_GRANT = NUM_MASTERS'(1) << DEFAULT_MASTER;

   function automatic logic [NUM_MASTERS-1:0] onehot(input logic [MNUM_W-1:0] n);
      onehot    = '0;
      onehot[n] = 1'b1;
   endfunction

   // Bit of a per-master vector picked by a master number
   function automatic logic bit_of(input logic [NUM_MASTERS-1:0] vec,
                                   input logic [MNUM_W-1:0]      n);
      bit_of = vec[n];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Selection

   // Parked masters stay masked until their completion bit arrives; a bit seen
   // in the same cycle already frees the master, saving a cycle of latency
   assign still_parked = parked_q & ~split_done;
   assign eligible     = bus_req & ~still_parked;

   prio_pick #(
      .N  (NUM_MASTERS),
      .IW (MNUM_W)
   ) u_pick (
      .cand  (eligible),
      .found (pick_found),
      .index (pick_idx)
   );

   // A locked owner keeps the grant even if it briefly drops its request;
   // a parked owner cannot hold, or a split locked master would stall the bus
   assign hold_bus = bit_of(lock_req, gnt_num_q) && !bit_of(parked_q, gnt_num_q);

   always_comb begin
      if (hold_bus) begin
         next_num = gnt_num_q;
      end else if (pick_found) begin
         next_num = pick_idx;
      end else begin
         next_num = DEFAULT_MASTER;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Grant register, re-arbitrated only at a transfer boundary

   // The lock flag travels with the grant so the broadcast matches the owner
   always_comb begin
      grant_d    = grant_q;
      gnt_num_d  = gnt_num_q;
      gnt_lock_d = gnt_lock_q;
      if (status.ready) begin
         grant_d    = onehot(next_num);
         gnt_num_d  = next_num;
         gnt_lock_d = hold_bus || bit_of(lock_req, next_num);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         grant_q    <= RESET_GRANT;
         gnt_num_q  <= DEFAULT_MASTER;
         gnt_lock_q <= 1'b0;
      end else begin
         grant_q    <= grant_d;
         gnt_num_q  <= gnt_num_d;
         gnt_lock_q <= gnt_lock_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Owner broadcast follows the address phase of the granted master

   // Grant and ready high together mean the master now drives address phase
   always_comb begin
      owner_d = owner_q;
      if (status.ready) begin
         owner_d.master   = gnt_num_q;
         owner_d.mastlock = gnt_lock_q;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         owner_q.master   <= DEFAULT_MASTER;
         owner_q.mastlock <= 1'b0;
      end else begin
         owner_q <= owner_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data phase tracking

   // Track which master owns the data phase so its response can be judged;
   // idle transfers always get an OKAY, so only a real transfer can be split
   always_comb begin
      data_num_d   = data_num_q;
      data_valid_d = data_valid_q;
      if (status.ready) begin
         data_num_d   = owner_q.master;
         data_valid_d = (status.trans != TRANS_IDLE);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data_num_q   <= DEFAULT_MASTER;
         data_valid_q <= 1'b0;
      end else begin
         data_num_q   <= data_num_d;
         data_valid_q <= data_valid_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Split parking

   // A split is recorded on its first cycle, while ready is still low, so the
   // master is already masked at the edge that ends the two-cycle response
   assign split_seen = data_valid_q && !status.ready && (status.resp == RESP_SPLIT);

   // Set wins: a fresh split on a master is recorded even if its old
   // completion bit is seen in the same cycle
   always_comb begin
      parked_d = still_parked;
      if (split_seen) begin
         parked_d = parked_d | onehot(data_num_q);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         parked_q <= '0;
      end else begin
         parked_q <= parked_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, straight from the registers

   assign grant = grant_q;
   assign owner = owner_q;
endmodule

/* test/arb_asserts.sv */
// Purpose: Port checker for the bus arbiter
// Assumes: One clock, rst async high
// Notes:   Split check skips the default master, which may idle-own
`timescale 1ns/1ps
module arb_asserts import arb_pkg::*; #(parameter int NUM_MASTERS = 16) (
   // Watched ports
   input wire logic clk,
   input wire logic rst,
   input wire logic [NUM_MASTERS-1:0] bus_req,
   input wire logic [NUM_MASTERS-1:0] lock_req,
   input wire arb_pkg::bus_status_s status,
   input wire logic [NUM_MASTERS-1:0] split_done,
   input wire logic [NUM_MASTERS-1:0] grant,
   input wire arb_pkg::owner_s owner
);
   function automatic logic [MNUM_W-1:0] hot_index(input logic [NUM_MASTERS-1:0] v);
      hot_index = '0;
      for (int i = 0; i < NUM_MASTERS; i++) begin
         if (v[i]) begin
            hot_index = MNUM_W'(i);
         end
      end
   endfunction
   wire [MNUM_W-1:0] gi = hot_index(grant);
   wire rdy = status.ready;
   // Data phase owner: the address owner one ready edge earlier
   logic [MNUM_W-1:0] dm_q;
   logic              dv_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dm_q <= '0;
         dv_q <= 1'b0;
      end else if (rdy) begin
         dm_q <= owner.master;
         dv_q <= (status.trans != TRANS_IDLE);
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_gnt_hot: assert property ($onehot(grant)) else $error("grant");
   a_gnt_hold: assert property (!rdy |=> $stable(grant)) else $error("grant");
   a_own_hold: assert property (!rdy |=> $stable(owner)) else $error("owner");
   a_own_next: assert property (rdy |=> owner.master == $past(gi)) else $error("owner");
   a_lock_keep: assert property (rdy && lock_req[gi] && status.resp != RESP_SPLIT |=> $stable(grant))
      else $error("lock");
   a_idle_dflt: assert property (rdy && !bus_req && !lock_req |=> grant[0]) else $error("idle");
   a_req_win: assert property (rdy && !lock_req |=> (grant & $past(bus_req)) || grant[0]) else $error("req");
   property split_park;
      logic [MNUM_W-1:0] m;
      (dv_q && status.resp == RESP_SPLIT && !rdy, m = dm_q) ##1 (rdy && !split_done[m] && m) |=> !grant[m];
   endproperty
   a_split_park: assert property (split_park) else $error("split");
   c_lock: cover property (rdy && lock_req[gi]);
   c_split: cover property (status.resp == RESP_SPLIT);
   c_wait: cover property (!rdy && bus_req != grant);
endmodule
bind bus_arbiter arb_asserts #(.NUM_MASTERS(NUM_MASTERS)) u_chk (.*);

/* test/slave_model.sv */
// Purpose: Slave side giving ready and responses
// Assumes: Controls move on falling edges
// Notes:   Split is one low-ready cycle, then the final one
`timescale 1ns/1ps
module slave_model import arb_pkg::*; (
   // Controls and status
   input wire logic clk,
   input wire logic stall,
   input wire logic split_go,
   output arb_pkg::bus_status_s status
);
   logic split_q = 1'b0;
   always @(posedge clk) split_q <= split_go;
   // Granted masters always present a real transfer once grant and ready meet
   assign status = '{!stall && !split_go, (split_go || split_q) ? RESP_SPLIT : RESP_OKAY, 2'h2};
endmodule

/* test/bus_arbiter_tb_top.sv */
// Purpose: Self-checking bench for the bus arbiter
// Assumes: Bench plays the masters
// Notes:   pick() predicts grant; owner follows one ready edge later
`timescale 1ns/1ps
module bus_arbiter_tb_top;
   logic clk = 1'b0, rst = 1'b1, stall = 1'b0, split_go = 1'b0;
   logic [15:0] req = '0, lck = '0, sdone = '0, parked = '0, grant;
   arb_pkg::bus_status_s status;
   arb_pkg::owner_s owner;
   int num_errors = 0, checked = 0, cur = 0;
   logic mlk = 1'b0;
   always #50 clk = ~clk;
   bus_arbiter dut (.clk, .rst, .bus_req(req), .lock_req(lck), .status, .split_done(sdone), .grant, .owner);
   slave_model u_slv (.clk, .stall, .split_go, .status);
   function automatic logic [15:0] pick(logic [15:0] r, l);
      if (l[cur] && !parked[cur]) return 16'h1 << cur;
      for (int i = 0; i < 16; i++) if (r[i] && !parked[i]) return 16'h1 << i;
      return 16'h1;
   endfunction
   task automatic cmp(string what, logic [15:0] exp, got);
      checked++;
      if (got !== exp) num_errors++;
      if (got !== exp) $display("unexpected %s expected %h seen %h", what, exp, got);
   endtask
   task automatic step(logic [15:0] r, l = '0, logic s = 1'b0);
      logic [15:0] e;
      @(negedge clk) {req, lck, stall} = {r, l, s};
      repeat (3) @(negedge clk);
      e = s ? 16'h1 << cur : pick(r, l);
      cur = $clog2(e);
      cmp("grant", e, grant);
      cmp("owner", 16'(cur), 16'(owner.master));
      mlk = s ? mlk : l[cur];
      cmp("mastlock", 16'(mlk), 16'(owner.mastlock));
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      void'($urandom(44349));
      repeat (8) @(negedge clk);
      cmp("reset", 16'h1, grant);
      cmp("reset owner", 16'h0, 16'(owner));
      rst = 1'b0;
      for (int k = 0; k < 12; k++) step(16'($urandom));
      step('0);
      step(16'h10, '0, 1'b1);
      step(16'h10);
      step(16'h20, 16'h20);
      step(16'h22, 16'h20);
      step(16'h2);
      step(16'h8);
      @(negedge clk) split_go = 1'b1;
      @(negedge clk) {split_go, parked[3]} = 2'b01;
      step(16'h8);
      @(negedge clk) {sdone[3], parked[3]} = 2'b10;
      @(negedge clk) sdone[3] = 1'b0;
      step(16'h8);
      step(16'h4, 16'h4);
      @(negedge clk) rst = 1'b1;
      @(negedge clk);
      cmp("reset", 16'h1, grant);
      cmp("reset owner", 16'h0, 16'(owner));
      rst = 1'b0;
      cur = 0;
      mlk = 1'b0;
      step(16'h4, 16'h4);
      stop_test();
   end
endmodule
